// ==== rtl/rdsw_top.v ====
/*
  Receive descriptor word 0 status write-back generator.
  Collects receive events over a frame and builds the updated
  descriptor word at each buffer-full or frame-end point.
  Assumes events come from logic on the same clock as pulses and
  that the DMA writes wb_word to memory when wb_valid is high.
*/
`timescale 1ns/100ps
`default_nettype none
`include "rdsw_regs.vh"

module rdsw_top (
  input wire clock,
  input wire reset_n,
  input wire [31:0] desc_word_in,
  input wire buf_full,
  input wire frame_end,
  input wire fifo_overflow_flag,
  input wire multicast_frame_flag,
  input wire residual_bit_flag,
  input wire too_long_flag,
  input wire too_short_flag,
  input wire phy_error_flag,
  input wire crc_error_flag,
  input wire mcast_err_mask,
  output reg wb_valid,
  output reg [31:0] wb_word
);

  // Position code for the word now being built, from the tracker
  wire [1:0] pos_code;

  // Write-back point: the buffer filled or the frame ended
  wire point;

  // Frame events: this cycle's pulses, their history, both joined
  wire [`RDSW_EVENT_W-1:0] ev_now;
  wire [`RDSW_EVENT_W-1:0] ev_held;
  wire [`RDSW_EVENT_W-1:0] ev_all;

  // Overflow history; kept apart since it never feeds the abort
  reg ovf_q;
  reg ovf_d;
  wire ovf_all;

  // Word image for a point, and the next values of the outputs
  wire [`RDSW_WORD_W-1:0] word_img;
  reg wb_valid_d;
  reg [`RDSW_WORD_W-1:0] wb_word_d;

  // Loop indices for the event history and the word image
  genvar gi;
  genvar gb;

  // Abort condition: a length, PHY or CRC error in the frame.
  // Residual bits and multicast are left out on purpose, so a
  // ragged tail alone does not flag the frame as aborted.
  function abort_of;
    input [`RDSW_EVENT_W-1:0] ev;
    begin
      abort_of = |ev[`RDSW_EV_LONG:`RDSW_EV_CRC];
    end
  endfunction

  // Error summary: the abort condition, plus multicast when the
  // mask lets it through; overflow alone never raises it
  function sum_of;
    input [`RDSW_EVENT_W-1:0] ev;
    input mask;
    begin
      sum_of = abort_of(ev) | (mask & ev[`RDSW_EV_MCAST]);
    end
  endfunction

  // One bit of the written-back word, chosen by its position.
  // Unnamed positions fall to the default and stay zero, so
  // software never reads back a stale bit it did not write.
  function word_bit;
    input integer idx;
    input [`RDSW_EVENT_W-1:0] ev;
    input ovf;
    input mask;
    input list_end;
    input [1:0] pos;
    begin
      case (idx)
        `RDSW_VALID_BIT: begin
          word_bit = 1'h0;
        end
        `RDSW_LIST_END_BIT: begin
          word_bit = list_end;
        end
        `RDSW_POS_HI_BIT: begin
          word_bit = pos[1];
        end
        `RDSW_POS_LO_BIT: begin
          word_bit = pos[0];
        end
        `RDSW_ERR_SUM_BIT: begin
          word_bit = sum_of(ev, mask);
        end
        `RDSW_OVF_BIT: begin
          word_bit = ovf;
        end
        `RDSW_ABORT_BIT: begin
          word_bit = abort_of(ev);
        end
        `RDSW_MCAST_BIT: begin
          word_bit = ev[`RDSW_EV_MCAST];
        end
        `RDSW_RESID_BIT: begin
          word_bit = ev[`RDSW_EV_RESID];
        end
        `RDSW_LONG_BIT: begin
          word_bit = ev[`RDSW_EV_LONG];
        end
        `RDSW_SHORT_BIT: begin
          word_bit = ev[`RDSW_EV_SHORT];
        end
        `RDSW_PHY_BIT: begin
          word_bit = ev[`RDSW_EV_PHY];
        end
        `RDSW_CRC_BIT: begin
          word_bit = ev[`RDSW_EV_CRC];
        end
        default: begin
          word_bit = 1'h0;
        end
      endcase
    end
  endfunction

  // Event index order must match the event defines in the header
  assign ev_now[`RDSW_EV_CRC] = crc_error_flag;
  assign ev_now[`RDSW_EV_PHY] = phy_error_flag;
  assign ev_now[`RDSW_EV_SHORT] = too_short_flag;
  assign ev_now[`RDSW_EV_LONG] = too_long_flag;
  assign ev_now[`RDSW_EV_RESID] = residual_bit_flag;
  assign ev_now[`RDSW_EV_MCAST] = multicast_frame_flag;

  // A point is any write-back request; the two never coincide
  assign point = buf_full | frame_end;

  // Tracker remembers whether earlier buffers of this frame went out
  rdsw_pos_track u_pos (
    .clock(clock),
    .reset_n(reset_n),
    .buf_full(buf_full),
    .frame_end(frame_end),
    .pos_code(pos_code)
  );

  // One history bit per frame event. Frame end clears it only
  // after the word is built, so a last-cycle event still lands.
  generate
    for (gi = 0; gi < `RDSW_EVENT_W; gi = gi + 1) begin : g_ev
      reg hold_q;
      reg hold_d;

      // Keep, add this cycle's pulse, or drop at frame end
      always @* begin
        hold_d = hold_q | ev_now[gi];
        if (frame_end) begin
          hold_d = 1'h0;
        end
      end

      // History flop of this event
      always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          hold_q <= 1'h0;
        end else begin
          hold_q <= hold_d;
        end
      end

      assign ev_held[gi] = hold_q;
    end
  endgenerate

  // Same-cycle events join the write-back, so none is lost
  assign ev_all = ev_held | ev_now;
  assign ovf_all = ovf_q | fifo_overflow_flag;

  // Overflow history, cleared with the others at frame end
  always @* begin
    ovf_d = ovf_all;
    if (frame_end) begin
      ovf_d = 1'h0;
    end
  end

  // Word image, one bit per position; list end passes through
  generate
    for (gb = 0; gb < `RDSW_WORD_W; gb = gb + 1) begin : g_word
      assign word_img[gb] = word_bit(gb, ev_all, ovf_all,
        mcast_err_mask, desc_word_in[`RDSW_LIST_END_BIT], pos_code);
    end
  endgenerate

  // Valid clear and status go out in one word, never split, so
  // software cannot catch a free descriptor with old status
  always @* begin
    wb_valid_d = point;
    wb_word_d = `RDSW_WORD_ZERO;
    if (point) begin
      wb_word_d = word_img;
    end
  end

  // Registered outputs; the word reads zero between points, which
  // keeps the memory side from latching a half-built value
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ovf_q <= 1'h0;
      wb_valid <= 1'h0;
      wb_word <= `RDSW_WORD_ZERO;
    end else begin
      ovf_q <= ovf_d;
      wb_valid <= wb_valid_d;
      wb_word <= wb_word_d;
    end
  end

endmodule
`default_nettype wire

// ==== rtl/rdsw_regs.vh ====
/*
  Constants for the receive descriptor status write-back block:
  word 0 field positions, position codes, event indices and widths.
  Assumes inclusion by bare name from the rdsw design files.

*/
`ifndef RDSW_REGS_VH
`define RDSW_REGS_VH

`define RDSW_VALID_BIT 31
`define RDSW_LIST_END_BIT 30
`define RDSW_POS_HI_BIT 29
`define RDSW_POS_LO_BIT 28
`define RDSW_ERR_SUM_BIT 27
`define RDSW_OVF_BIT 9
`define RDSW_ABORT_BIT 8
`define RDSW_MCAST_BIT 7
`define RDSW_RESID_BIT 4
`define RDSW_LONG_BIT 3
`define RDSW_SHORT_BIT 2
`define RDSW_PHY_BIT 1
`define RDSW_CRC_BIT 0

`define RDSW_POS_MIDDLE 2'h0
`define RDSW_POS_END 2'h1
`define RDSW_POS_START 2'h2
`define RDSW_POS_WHOLE 2'h3

`define RDSW_EVENT_W 6
`define RDSW_EV_CRC 0
`define RDSW_EV_PHY 1
`define RDSW_EV_SHORT 2
`define RDSW_EV_LONG 3
`define RDSW_EV_RESID 4
`define RDSW_EV_MCAST 5
`define RDSW_WORD_W 32
`define RDSW_WORD_ZERO 32'h00000000

`endif

// ==== rtl/rdsw_pos_track.v ====
/*
  Frame position tracker: remembers whether the next write-back
  belongs to a frame already started, and gives the position code.
  Assumes buf_full and frame_end are one-cycle pulses, never together.
*/
`timescale 1ns/100ps
`default_nettype none
`include "rdsw_regs.vh"

module rdsw_pos_track (
  input wire clock,
  input wire reset_n,
  input wire buf_full,
  input wire frame_end,
  output reg [1:0] pos_code
);

  reg in_frame_q;
  reg in_frame_d;

  // Code chosen from whether earlier buffers of this frame went out
  always @* begin
    in_frame_d = in_frame_q;
    pos_code = `RDSW_POS_WHOLE;
    if (buf_full) begin
      pos_code = in_frame_q ? `RDSW_POS_MIDDLE : `RDSW_POS_START;
      in_frame_d = 1'h1;
    end else if (frame_end) begin
      pos_code = in_frame_q ? `RDSW_POS_END : `RDSW_POS_WHOLE;
      in_frame_d = 1'h0;
    end
  end

  // Frame continuation state
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      in_frame_q <= 1'h0;
    end else begin
      in_frame_q <= in_frame_d;
    end
  end

endmodule
`default_nettype wire

// ==== verif/rdsw_monitor.sv ====
/* Port checks on rdsw_top; one clock. */
`timescale 1ns/100ps
`default_nettype none
module rdsw_monitor (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic buf_full,
  input wire logic frame_end,
  input wire logic wb_valid,
  input wire logic [31:0] wb_word
);
  wire [1:0] pos = wb_word[29:28];
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // Two points back to back
  sequence s_ff; frame_end ##1 frame_end; endsequence
  sequence s_bf; buf_full ##1 frame_end; endsequence
  sequence s_fb; frame_end ##1 buf_full; endsequence
  sequence s_bb; buf_full ##1 buf_full; endsequence
  property p_ans; buf_full || frame_end |=> wb_valid; endproperty
  a_ans: assert property (p_ans) else $error("late");
  property p_idle; !wb_valid |-> !wb_word; endproperty
  a_idle: assert property (p_idle) else $error("stray");
  property p_one; s_ff |=> pos == 2'h3; endproperty
  a_one: assert property (p_one) else $error("pos");
  property p_end; s_bf |=> pos == 2'h1; endproperty
  a_end: assert property (p_end) else $error("pos");
  property p_sta; s_fb |=> pos == 2'h2; endproperty
  a_sta: assert property (p_sta) else $error("pos");
  property p_mid; s_bb |=> pos == 2'h0; endproperty
  a_mid: assert property (p_mid) else $error("pos");
  property p_ab; wb_valid |-> wb_word[8] == |wb_word[3:0]; endproperty
  a_ab: assert property (p_ab) else $error("abort");
  property p_sum; wb_valid && !wb_word[7] |-> wb_word[27] == wb_word[8];
  endproperty
  a_sum: assert property (p_sum) else $error("sum");
endmodule
`default_nettype wire

// ==== verif/rdsw_soft.sv ====
/* Software model of word 0; assumes frame_end pulses. */
`timescale 1ns/100ps
`default_nettype none
module rdsw_soft (
  input wire logic clock,
  input wire logic frame_end,
  output logic [31:0] desc_word
);
  logic le_q = 1'h0;
  // List end flips per frame
  always @(posedge clock) if (frame_end) le_q <= !le_q;
  assign desc_word = {1'h1, le_q, 30'h0};
endmodule
`default_nettype wire

// ==== verif/tb.sv ====
/* Random bench with model; assumes rdsw_soft. */
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clock = 0, reset_n = 0, buf_full = 0, frame_end = 0;
  logic mcast_err_mask = 0, wb_valid, mid = 0;
  logic [9:0] ev = 0;
  logic [31:0] dw, wb_word, acc = 0, e;
  logic [32:0] xp = 0;
  int n_mismatch = 0, samples_checked = 0, r;
  always #20 clock = !clock;
  rdsw_soft sw_u (.clock(clock), .frame_end(frame_end), .desc_word(dw));
  rdsw_top dut_u (.clock(clock), .reset_n(reset_n), .desc_word_in(dw),
    .buf_full(buf_full), .frame_end(frame_end),
    .fifo_overflow_flag(ev[9]), .multicast_frame_flag(ev[7]),
    .residual_bit_flag(ev[4]), .too_long_flag(ev[3]),
    .too_short_flag(ev[2]), .phy_error_flag(ev[1]),
    .crc_error_flag(ev[0]), .mcast_err_mask(mcast_err_mask),
    .wb_valid(wb_valid), .wb_word(wb_word));
  task chk(input logic [32:0] s, x);
    samples_checked++;
    if (s !== x) begin
      n_mismatch++;
      $display("CHECK FAILED wb exp %h got %h", x, s);
    end
  endtask
  task stop_test;
    if (n_mismatch == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Model sees the inputs taken at this edge, then drives new ones
  initial begin
    void'($urandom(32'h3493b1ed));
    repeat (12) @(posedge clock);
    reset_n <= 1'h1;
    repeat (3000) begin
      @(posedge clock);
      chk({wb_valid, wb_word}, xp);
      e = acc | ev;
      e[8] = |e[3:0];
      xp = (buf_full | frame_end) ? {2'h2, dw[30], !mid, frame_end,
        e[8] | mcast_err_mask & e[7], 17'h0, e[9:0]} : 33'h0;
      mid = buf_full | mid & !frame_end;
      acc = frame_end ? 32'h0 : e;
      r = $urandom % 4;
      buf_full <= r == 1;
      frame_end <= r > 1;
      ev <= 10'($urandom & $urandom & $urandom) & 10'h29f;
      mcast_err_mask <= 1'($urandom);
    end
    stop_test;
  end
  // Hang guard past the planned run
  initial begin
    #200000 n_mismatch++;
    stop_test;
  end
endmodule
bind rdsw_top rdsw_monitor mon_u (.clock(clock), .reset_n(reset_n),
  .buf_full(buf_full), .frame_end(frame_end), .wb_valid(wb_valid),
  .wb_word(wb_word));
`default_nettype wire
